// *** hpc_ctrl.sv ***
module hpc_ctrl #(
  parameter int DEB_CYC = hpc_pkg::DEB_CYC,
  parameter int START_CYC = hpc_pkg::START_CYC,
  parameter int RETRY_CYC = hpc_pkg::RETRY_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins and comparators
  input wire hpc_pkg::hpc_pins_s pins_i,
  // Converter
  input wire logic adc_done,
  input wire logic [7:0] adc_code,
  output logic [1:0] adc_sel,
  output logic adc_start,
  // Gate and current limit
  output logic gate_on,
  output logic hi_limit,
  // Open-drain alert pin
  output logic alert_o,
  output logic alert_oe_n,
  // Open-drain general purpose pin
  output logic gpio_o,
  output logic gpio_oe_n
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  hpc_pkg::hpc_pins_s s1_q, s2_q, s3_q;  // Sync stages and edge history
  hpc_pkg::hpc_state_e st_q, st_d;  // Power state
  logic [7:0] ctrl_q;  // Control register
  logic [4:0] fault_q, fault_d;  // Sticky faults
  logic [4:0] amask_q;  // Alert enables
  logic [31:0] deb_q;  // Qualification counter
  logic ready_q, ready_p;  // Conditions held long enough
  logic [hpc_pkg::TMR_W-1:0] tmr_q;  // Start-up / cool-down timer
  logic [9:0] brk_q;  // Breaker delay counter
  logic brk_trip;  // Breaker delay expired
  logic init_p;  // Initialisation pulse
  logic [1:0] prime_q;  // Edges seen since reset, saturating
  logic hist_ok;  // Edge history holds real pin data
  logic req_rise, req_fall, card_fall, card_edge;
  logic cond_ok, block, stop, st_done, cool_done, oc_set, clr_all;
  logic wr_q, act_q;  // Data phase pending
  logic [7:0] addr_q;  // Latched address
  logic wr_en;  // Write commits this cycle
  logic [7:0] adc_res [3];  // Converter results
  logic adc_busy_q;  // Conversion in flight

  // Address match used by the write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Two flops, then a third for edge history
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------
  // Edge history priming
  // ----------------------------------------
  // Counts the first edges after reset; the history stage holds reset
  // values until then, which would fake edges against idle pins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prime_q <= 2'h0;
    end else if (prime_q != 2'h3) begin
      prime_q <= prime_q + 2'h1;  // Saturates once history is real
    end
  end
  assign hist_ok = (prime_q == 2'h3);

  // Edge events from the second stage onward
  // Pin edges wait for real history; init stays open for power-up
  assign init_p = s2_q.lock_ok & ~s3_q.lock_ok;
  assign req_rise = hist_ok & s2_q.req & ~s3_q.req;
  assign req_fall = hist_ok & ~s2_q.req & s3_q.req;
  assign card_fall = hist_ok & ~s2_q.card_out & s3_q.card_out;
  assign card_edge = hist_ok & (s2_q.card_out ^ s3_q.card_out);

  // ----------------------------------------
  // Turn-on qualification
  // ----------------------------------------
  // Input range good, card seated, supply up
  assign cond_ok = s2_q.lock_ok & ~s2_q.card_out & ~s2_q.low_in & ~s2_q.high_in & ~s2_q.sup_hi;

  // Conditions must hold unbroken before the request is sampled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      deb_q <= '0;
      ready_q <= 1'b0;
    end else if (!cond_ok || init_p) begin
      deb_q <= '0;
      ready_q <= 1'b0;
    end else if (deb_q == DEB_CYC - 1) begin
      ready_q <= 1'b1;
    end else begin
      deb_q <= deb_q + 32'h1;
    end
  end
  assign ready_p = cond_ok & ~init_p & ~ready_q & (deb_q == DEB_CYC - 1);

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign hreadyout = 1'b1;  // Zero wait states
  assign hresp = 1'b0;  // Always OKAY

  // Latch address phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= '0;
    end else if (hready) begin
      act_q <= hsel & htrans[1];
      wr_q <= hsel & htrans[1] & hwrite;
      addr_q <= haddr[7:0];
    end
  end
  assign wr_en = wr_q & hready;

  // Read data registered at the address phase; unmapped reads zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        hpc_pkg::OFF_CTRL: hrdata <= {24'h0, ctrl_q};
        hpc_pkg::OFF_ALERT: hrdata <= {27'h0, amask_q};
        hpc_pkg::OFF_FAULT: hrdata <= {27'h0, fault_q};
        hpc_pkg::OFF_STAT: hrdata <= {22'h0, st_q, s2_q.gpio_in, s2_q.pwr_good, s2_q.card_out,
                                      s2_q.req, s2_q.breaker, s2_q.low_in, s2_q.high_in | s2_q.sup_hi, ready_q};
        hpc_pkg::OFF_ADC0: hrdata <= {24'h0, adc_res[0]};
        hpc_pkg::OFF_ADC1: hrdata <= {24'h0, adc_res[1]};
        hpc_pkg::OFF_ADC2: hrdata <= {24'h0, adc_res[2]};
        default: hrdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Control and alert mask registers
  // ----------------------------------------
  // Init wins; else bus write; else qualification sample; else pin edges
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= hpc_pkg::CTRL_RST;
    end else if (init_p) begin
      ctrl_q <= hpc_pkg::CTRL_RST;
    end else if (wr_en && hit(addr_q, hpc_pkg::OFF_CTRL)) begin
      ctrl_q <= hwdata[7:0];
    end else if (ready_p) begin
      ctrl_q[hpc_pkg::CB_FET] <= s2_q.req;
    end else if (req_rise) begin
      ctrl_q[hpc_pkg::CB_FET] <= 1'b1;
    end else if (req_fall) begin
      ctrl_q[hpc_pkg::CB_FET] <= 1'b0;
    end
  end

  // Alert enables
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      amask_q <= hpc_pkg::ALERT_RST;
    end else if (init_p) begin
      amask_q <= hpc_pkg::ALERT_RST;
    end else if (wr_en && hit(addr_q, hpc_pkg::OFF_ALERT)) begin
      amask_q <= hwdata[4:0];
    end
  end

  // ----------------------------------------
  // Fault register
  // ----------------------------------------
  // Events set; clears never swallow a same-cycle event
  assign clr_all = init_p | req_fall | card_fall | s2_q.low_rst;
  always_comb begin
    fault_d = fault_q;
    if (clr_all) begin
      fault_d = '0;
    end else if (wr_en && hit(addr_q, hpc_pkg::OFF_FAULT)) begin
      fault_d = fault_q & ~hwdata[4:0];  // Write one to clear
    end
    if (s2_q.lock_ok) begin
      fault_d[hpc_pkg::FB_HIGH] = fault_d[hpc_pkg::FB_HIGH] | s2_q.high_in | s2_q.sup_hi;
      fault_d[hpc_pkg::FB_LOW] = fault_d[hpc_pkg::FB_LOW] | (s2_q.low_in & ~s2_q.low_rst);
      fault_d[hpc_pkg::FB_PBAD] = fault_d[hpc_pkg::FB_PBAD] | ((st_q == hpc_pkg::ST_ON) & ~s2_q.pwr_good);
    end
    fault_d[hpc_pkg::FB_OC] = fault_d[hpc_pkg::FB_OC] | oc_set;
    fault_d[hpc_pkg::FB_CARD] = fault_d[hpc_pkg::FB_CARD] | card_edge;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_q <= hpc_pkg::FAULT_RST;
    end else begin
      fault_q <= fault_d;
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  // Overvoltage, undervoltage and overcurrent faults hold the gate off when their auto-retry is clear
  assign block = (fault_q[hpc_pkg::FB_HIGH] & ~ctrl_q[hpc_pkg::CB_HIGH_RETRY])
               | (fault_q[hpc_pkg::FB_LOW] & ~ctrl_q[hpc_pkg::CB_LOW_RETRY])
               | (fault_q[hpc_pkg::FB_OC] & ~ctrl_q[hpc_pkg::CB_OC_RETRY]);
  assign stop = ~ctrl_q[hpc_pkg::CB_FET] | ~cond_ok | block;

  // Internal timers when the timer pin is tied high
  assign st_done = s2_q.tmr_tied ? (tmr_q == hpc_pkg::TMR_W'(START_CYC - 1)) : s2_q.tmr_thr;
  assign cool_done = s2_q.tmr_tied ? (tmr_q == hpc_pkg::TMR_W'(RETRY_CYC - 1)) : s2_q.cooldown;
  assign brk_trip = (brk_q == 10'(hpc_pkg::BRK_CYC));
  assign oc_set = ((st_q == hpc_pkg::ST_START) & ~stop & st_done & s2_q.in_limit)
                | ((st_q == hpc_pkg::ST_ON) & ~stop & brk_trip);

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      hpc_pkg::ST_OFF: begin
        if (!stop && ready_q) begin
          st_d = hpc_pkg::ST_START;
        end
      end
      hpc_pkg::ST_START: begin
        if (stop) begin
          st_d = hpc_pkg::ST_OFF;
        end else if (st_done) begin
          st_d = s2_q.in_limit ? hpc_pkg::ST_COOL : hpc_pkg::ST_ON;
        end
      end
      hpc_pkg::ST_ON: begin
        if (stop) begin
          st_d = hpc_pkg::ST_OFF;
        end else if (brk_trip) begin
          st_d = hpc_pkg::ST_COOL;
        end
      end
      hpc_pkg::ST_COOL: begin
        if (cool_done) begin
          st_d = hpc_pkg::ST_OFF;
        end
      end
      default: st_d = hpc_pkg::ST_OFF;
    endcase
    if (init_p || !s2_q.lock_ok) begin
      st_d = hpc_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= hpc_pkg::ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // Timer restarts on every state change
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= '0;
    end else if (st_d != st_q) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  // Breaker armed only once fully on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      brk_q <= '0;
    end else if (st_q != hpc_pkg::ST_ON || !s2_q.breaker) begin
      brk_q <= '0;
    end else if (!brk_trip) begin
      brk_q <= brk_q + 10'h1;
    end
  end

  // Gate and current limit select from the state
  assign gate_on = (st_q == hpc_pkg::ST_START) | (st_q == hpc_pkg::ST_ON);
  assign hi_limit = (st_q == hpc_pkg::ST_ON);

  // ----------------------------------------
  // Alert and general purpose pins
  // ----------------------------------------
  assign alert_o = 1'b0;
  assign alert_oe_n = ~|(fault_q & amask_q);

  // Pin pulls low when enable is low
  assign gpio_o = 1'b0;
  always_comb begin
    case (ctrl_q[hpc_pkg::CB_GCFG_HI:hpc_pkg::CB_GCFG_LO])
      hpc_pkg::GP_GOOD: gpio_oe_n = hi_limit & s2_q.pwr_good;
      hpc_pkg::GP_BAD: gpio_oe_n = ~(hi_limit & s2_q.pwr_good);
      hpc_pkg::GP_IN: gpio_oe_n = 1'b1;
      default: gpio_oe_n = ctrl_q[hpc_pkg::CB_GPO];
    endcase
  end

  // ----------------------------------------
  // Converter multiplexer
  // ----------------------------------------
  // Cycle aux pin, output source, supply minus sense
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      adc_sel <= 2'h0;
      adc_start <= 1'b0;
      adc_busy_q <= 1'b0;
      adc_res <= '{default: 8'h00};
    end else begin
      adc_start <= 1'b0;
      if (!adc_busy_q) begin
        adc_start <= 1'b1;
        adc_busy_q <= 1'b1;
      end else if (adc_done) begin
        adc_res[adc_sel] <= adc_code;
        adc_sel <= (adc_sel == 2'h2) ? 2'h0 : adc_sel + 2'h1;
        adc_busy_q <= 1'b0;
      end
    end
  end

endmodule

// *** hpc_pkg.sv ***
package hpc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;  // System clock rate
  localparam int T_DEB_MS = 100;  // Turn-on qualification time
  localparam int T_START_MS = 100;  // Internal start-up time
  localparam int T_RETRY_S = 5;  // Internal cool-down time
  localparam int T_BRK_US = 20;  // Breaker delay
  localparam int DEB_CYC = T_DEB_MS * (CLK_HZ / 1000);
  localparam int START_CYC = T_START_MS * (CLK_HZ / 1000);
  localparam int RETRY_CYC = T_RETRY_S * CLK_HZ;
  localparam int BRK_CYC = T_BRK_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W = 28;  // Wide enough for the cool-down count

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ALERT = 8'h04;
  localparam logic [7:0] OFF_FAULT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_ADC0 = 8'h10;
  localparam logic [7:0] OFF_ADC1 = 8'h14;
  localparam logic [7:0] OFF_ADC2 = 8'h18;

  // ----------------------------------------
  // Control fields and reset value
  // ----------------------------------------
  localparam int CB_HIGH_RETRY = 0;  // Overvoltage auto-retry
  localparam int CB_LOW_RETRY = 1;  // Undervoltage auto-retry
  localparam int CB_OC_RETRY = 2;  // Overcurrent auto-retry
  localparam int CB_FET = 3;  // fet_drive_bit
  localparam int CB_GPO = 4;  // General purpose output level
  localparam int CB_GCFG_LO = 6;  // gpio_cfg_low_bit
  localparam int CB_GCFG_HI = 7;  // gpio_cfg_high_bit
  localparam logic [7:0] CTRL_RST = 8'h03;

  // ----------------------------------------
  // Fault fields
  // ----------------------------------------
  localparam int FB_HIGH = 0;  // Overvoltage
  localparam int FB_LOW = 1;  // Undervoltage
  localparam int FB_OC = 2;  // Overcurrent
  localparam int FB_PBAD = 3;  // Power bad
  localparam int FB_CARD = 4;  // Card seated pin changed
  localparam int FAULT_W = 5;
  localparam logic [4:0] FAULT_RST = 5'h00;
  localparam logic [4:0] ALERT_RST = 5'h00;

  // ----------------------------------------
  // General purpose pin modes
  // ----------------------------------------
  localparam logic [1:0] GP_GOOD = 2'h0;  // Pull low while power not good
  localparam logic [1:0] GP_BAD = 2'h1;  // Pull low while power good
  localparam logic [1:0] GP_IN = 2'h2;  // Input only
  localparam logic [1:0] GP_OUT = 2'h3;  // Open-drain output

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_OFF, ST_START, ST_ON, ST_COOL} hpc_state_e;

  // Pins and comparator outputs from outside the clock domain
  typedef struct packed {
    logic req;  // Power switch request pin
    logic card_out;  // Card seated pin, high when no card
    logic low_in;  // Low input below 1.227V
    logic low_rst;  // Low input below 0.4V
    logic high_in;  // High input above 1.235V
    logic sup_hi;  // Supply above 15.6V
    logic breaker;  // Sense above 25mV
    logic pwr_good;  // Output divider above threshold
    logic cooldown;  // Timer pin below 0.2V
    logic tmr_thr;  // Timer pin reached start-up threshold
    logic in_limit;  // Inrush current being limited
    logic tmr_tied;  // Timer pin tied to internal supply
    logic gpio_in;  // General purpose pin level
    logic lock_ok;  // Internal supply above lockout
  } hpc_pins_s;

endpackage

// *** hpc_ctrl_props.sv ***
module hpc_ctrl_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Bus
  input wire logic [1:0] htrans,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins and converter
  input wire hpc_pkg::hpc_pins_s pins_i,
  input wire logic [1:0] adc_sel,
  input wire logic adc_start,
  // Drives
  input wire logic gate_on,
  input wire logic hi_limit,
  input wire logic alert_o,
  input wire logic gpio_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ----
  // Sequences
  // ----
  // Short breaker burst while on
  sequence s_brk;
    $rose(pins_i.breaker) ##0 hi_limit ##1 pins_i.breaker [*7];
  endsequence
  // Request pin dropped and stays low
  sequence s_req;
    $fell(pins_i.req) ##1 !pins_i.req [*5];
  endsequence
  // ----
  // Properties
  // ----
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or error");
  property p_card;
    pins_i.card_out [*5] |-> !gate_on;
  endproperty
  a_card: assert property (p_card) else $error("gate on with no card");
  property p_low;
    pins_i.low_in [*5] |-> !gate_on;
  endproperty
  a_low: assert property (p_low) else $error("gate on at low input");
  property p_high;
    pins_i.high_in [*5] |-> !gate_on;
  endproperty
  a_high: assert property (p_high) else $error("gate on at high input");
  property p_sup;
    pins_i.sup_hi [*5] |-> !gate_on;
  endproperty
  a_sup: assert property (p_sup) else $error("gate on at supply high");
  property p_lim;
    hi_limit |-> gate_on;
  endproperty
  a_lim: assert property (p_lim) else $error("high limit with gate off");
  property p_rise;
    $rose(hi_limit) |-> $past(gate_on, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("on state without start");
  property p_adc;
    adc_start |=> !adc_start;
  endproperty
  a_adc: assert property (p_adc) else $error("start pulse too long");
  property p_sel;
    adc_sel != 2'h3;
  endproperty
  a_sel: assert property (p_sel) else $error("bad mux select");
  property p_od;
    !alert_o && !gpio_o;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_brk;
    s_brk |=> hi_limit;
  endproperty
  a_brk: assert property (p_brk) else $error("breaker tripped early");
  property p_req;
    (!htrans[1] throughout s_req) |-> !gate_on;
  endproperty
  a_req: assert property (p_req) else $error("gate on after request fall");
endmodule

bind hpc_ctrl hpc_ctrl_props u_props (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .htrans(htrans),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .pins_i(pins_i),
  .adc_sel(adc_sel),
  .adc_start(adc_start),
  .gate_on(gate_on),
  .hi_limit(hi_limit),
  .alert_o(alert_o),
  .gpio_o(gpio_o)
);

// *** hpc_conv_model.sv ***
module hpc_conv_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Converter handshake
  input wire logic adc_start,
  input wire logic [1:0] adc_sel,
  output logic adc_done,
  output logic [7:0] adc_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q; // Conversion countdown
  logic done_q; // One-cycle result strobe
  logic [7:0] code_q; // Result, toggles when not valid
  // Code per channel, garbage outside the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      done_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      code_q <= ~code_q;
      if (adc_start) begin
        cnt_q <= 2'h3;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          done_q <= 1'b1;
          code_q <= 8'ha0 + {6'h00, adc_sel};
        end
      end
    end
  end
  assign adc_done = done_q;
  assign adc_code = code_q;
endmodule

// *** hpc_ctrl_tb.sv ***
module hpc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 50;
  localparam int STRT = 40;
  localparam int RTRY = 60;
  // ----
  // Signals
  // ----
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  hpc_pkg::hpc_pins_s pins = hpc_pkg::hpc_pins_s'(14'h2045); // Request, good, tied, lock
  logic [31:0] hrdata;
  logic hreadyout, hresp, adc_done, adc_start, gate_on, hi_limit;
  logic alert_o, alert_oe_n, gpio_o, gpio_oe_n;
  logic [7:0] adc_code;
  logic [1:0] adc_sel;
  logic [31:0] rd;
  int fails = 0;
  int checks = 0;
  int cnt;
  logic [13:0] trip_m [3] = '{14'h0800, 14'h0200, 14'h0100}; // Low, high, supply
  logic [31:0] trip_f [3] = '{32'h2, 32'h1, 32'h1};
  // ----
  // Instances
  // ----
  hpc_ctrl #(.DEB_CYC(DEB), .START_CYC(STRT), .RETRY_CYC(RTRY)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins_i(pins), .adc_done(adc_done),
    .adc_code(adc_code), .adc_sel(adc_sel), .adc_start(adc_start), .gate_on(gate_on),
    .hi_limit(hi_limit), .alert_o(alert_o), .alert_oe_n(alert_oe_n), .gpio_o(gpio_o),
    .gpio_oe_n(gpio_oe_n));
  hpc_conv_model u_conv (.clk_sys(clk_sys), .rstn(rstn), .adc_start(adc_start),
    .adc_sel(adc_sel), .adc_done(adc_done), .adc_code(adc_code));
  // Clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----
  // Tasks
  // ----
  task summarize;
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One AHB single transfer, zero or more waits
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Bounded wait for gate level, cycles waited in cnt
  task wait_gate(input logic v, input int n);
    cnt = 0;
    while (cnt < n && gate_on !== v) begin
      @(posedge clk_sys);
      cnt++;
    end
    chkb(gate_on, v);
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_gate(1'b1, 300);
    chkb(cnt >= DEB, 1'b1);
    rdm(hpc_pkg::OFF_CTRL, 32'hffffffff, 32'h0b);
    rdm(hpc_pkg::OFF_ALERT, 32'hffffffff, 32'h0);
    rdm(8'h40, 32'hffffffff, 32'h0);
    repeat (STRT) @(posedge clk_sys);
    chkb(hi_limit, 1'b1);
    rdm(hpc_pkg::OFF_STAT, 32'h300, 32'h200);
    chkb(gpio_oe_n, 1'b1);
    pins.pwr_good <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chkb(gpio_oe_n, 1'b0);
    pins.pwr_good <= 1'b1;
    rdm(hpc_pkg::OFF_FAULT, 32'h1f, 32'h08);
    for (int m = 0; m < 4; m++) begin
      wr(hpc_pkg::OFF_CTRL, 32'h0b | (m << 6));
      repeat (3) @(posedge clk_sys);
      chkb(gpio_oe_n, ~m[0]);
    end
    wr(hpc_pkg::OFF_CTRL, 32'hdb);
    repeat (3) @(posedge clk_sys);
    chkb(gpio_oe_n, 1'b1);
    wr(hpc_pkg::OFF_CTRL, 32'h0b);
    wr(hpc_pkg::OFF_ALERT, 32'h08);
    repeat (4) @(posedge clk_sys);
    chkb(alert_oe_n, 1'b0);
    wr(hpc_pkg::OFF_FAULT, 32'h08);
    repeat (4) @(posedge clk_sys);
    chkb(alert_oe_n, 1'b1);
    // Short burst must not trip, long one must
    pins.breaker <= 1'b1;
    repeat (20) @(posedge clk_sys);
    pins.breaker <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chkb(gate_on, 1'b1);
    pins.breaker <= 1'b1;
    wait_gate(1'b0, 900);
    chkb(cnt >= 800, 1'b1);
    rdm(hpc_pkg::OFF_FAULT, 32'h04, 32'h04);
    pins.breaker <= 1'b0;
    repeat (RTRY + 100) @(posedge clk_sys);
    chkb(gate_on, 1'b0);
    wr(hpc_pkg::OFF_CTRL, 32'h0f);
    wait_gate(1'b1, 100);
    wr(hpc_pkg::OFF_FAULT, 32'h1f);
    // Input range faults, auto-retry after clearing
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      pins <= hpc_pkg::hpc_pins_s'(pins | trip_m[i]);
      wait_gate(1'b0, 20);
      rdm(hpc_pkg::OFF_FAULT, 32'h1f, trip_f[i]);
      pins <= hpc_pkg::hpc_pins_s'(pins & ~trip_m[i]);
      wr(hpc_pkg::OFF_FAULT, 32'h1f);
      wait_gate(1'b1, DEB + 60);
    end
    pins.low_in <= 1'b1;
    pins.low_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdm(hpc_pkg::OFF_FAULT, 32'h1f, 32'h0);
    pins.low_in <= 1'b0;
    pins.low_rst <= 1'b0;
    wait_gate(1'b1, DEB + 60);
    repeat (STRT + 10) @(posedge clk_sys);
    pins.pwr_good <= 1'b0;
    repeat (8) @(posedge clk_sys);
    pins.pwr_good <= 1'b1;
    pins.req <= 1'b0;
    wait_gate(1'b0, 20);
    rdm(hpc_pkg::OFF_FAULT, 32'h1f, 32'h0);
    pins.req <= 1'b1;
    wait_gate(1'b1, 20);
    pins.card_out <= 1'b1;
    wait_gate(1'b0, 20);
    rdm(hpc_pkg::OFF_FAULT, 32'h10, 32'h10);
    pins.card_out <= 1'b0;
    wait_gate(1'b1, DEB + 60);
    chkb(cnt >= DEB, 1'b1);
    rdm(hpc_pkg::OFF_ADC0, 32'hff, 32'ha0);
    rdm(hpc_pkg::OFF_ADC1, 32'hff, 32'ha1);
    rdm(hpc_pkg::OFF_ADC2, 32'hff, 32'ha2);
    // Timer pin mode: start-up into a limit, cool-down on the comparator
    pins.tmr_tied <= 1'b0;
    pins.in_limit <= 1'b1;
    repeat (STRT + 20) @(posedge clk_sys);
    chkb(gate_on, 1'b1);
    pins.tmr_thr <= 1'b1;
    wait_gate(1'b0, 20);
    rdm(hpc_pkg::OFF_FAULT, 32'h04, 32'h04);
    pins.tmr_thr <= 1'b0;
    pins.in_limit <= 1'b0;
    repeat (RTRY + 20) @(posedge clk_sys);
    chkb(gate_on, 1'b0);
    pins.cooldown <= 1'b1;
    wait_gate(1'b1, 20);
    pins.cooldown <= 1'b0;
    pins.tmr_tied <= 1'b1;
    // Supply lockout rise re-initialises
    wr(hpc_pkg::OFF_CTRL, 32'hcf);
    pins.lock_ok <= 1'b0;
    repeat (5) @(posedge clk_sys);
    pins.lock_ok <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chkb(gate_on, 1'b0);
    rdm(hpc_pkg::OFF_CTRL, 32'hff, 32'h03);
    summarize;
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    summarize;
  end
endmodule
